/* hdl/cadp_pkg.sv */
// Constants, register map and operation codes of the conditional arithmetic datapath.
package cadp_pkg;

  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [7:0] CADP_OFF_OPA = 8'h00;
  localparam logic [7:0] CADP_OFF_OPB = 8'h04;
  localparam logic [7:0] CADP_OFF_OPC = 8'h08;
  localparam logic [7:0] CADP_OFF_OPD = 8'h0C;
  localparam logic [7:0] CADP_OFF_CTRL = 8'h10;
  localparam logic [7:0] CADP_OFF_RES_LO = 8'h14;
  localparam logic [7:0] CADP_OFF_RES_HI = 8'h18;
  localparam logic [7:0] CADP_OFF_STATUS = 8'h1C;
  localparam logic [7:0] CADP_OFF_ICR = 8'h20;
  localparam logic [7:0] CADP_OFF_CFG = 8'h24;

  // ==========================================================================
  // Control word fields.
  localparam int CADP_CTRL_OP_LSB = 0;
  localparam int CADP_CTRL_IMM_BIT = 5;
  localparam int CADP_CTRL_K4_LSB = 6;
  localparam int CADP_CTRL_POS_LSB = 10;
  localparam int CADP_CTRL_SC_LSB = 15;

  // ==========================================================================
  // Status, interrupt control and configuration bits.
  localparam int CADP_ST_V = 0;
  localparam int CADP_ST_SV = 1;
  localparam int CADP_ST_AV = 2;
  localparam int CADP_ST_SAV = 3;
  localparam int CADP_ST_DBG = 4;
  localparam int CADP_ST_BUSY = 5;
  localparam int CADP_GLOBAL_INTERRUPT_ENABLE_BIT = 0;
  localparam int CADP_CFG_DBG_EN = 0;

  // ==========================================================================
  // Reset values and division setup shifts.
  localparam logic [31:0] CADP_RST_WORD = 32'h0000_0000;
  localparam logic [5:0] CADP_SHIFT_WORD = 6'h00;
  localparam logic [5:0] CADP_SHIFT_HALF = 6'h10;
  localparam logic [5:0] CADP_SHIFT_BYTE = 6'h18;
  localparam logic [63:0] CADP_FILL_HALF = 64'h0000_0000_0000_FFFF;
  localparam logic [63:0] CADP_FILL_BYTE = 64'h0000_0000_00FF_FFFF;

  typedef enum logic [4:0] {
    CADP_OP_NOP, CADP_OP_CLZ_B, CADP_OP_CLZ_H, CADP_OP_CMOV, CADP_OP_CMOVN,
    CADP_OP_CSUB, CADP_OP_CSUBN, CADP_OP_CSUB_A, CADP_OP_CSUBN_A, CADP_OP_DEBUG,
    CADP_OP_DEXTR, CADP_OP_DIFSC, CADP_OP_DISABLE, CADP_OP_ENABLE, CADP_OP_DSYNC,
    CADP_OP_DVADJ, CADP_OP_DVINIT, CADP_OP_DVINIT_U, CADP_OP_DVINIT_B,
    CADP_OP_DIVISION_SETUP_BYTE_UNSIGNED, CADP_OP_DVINIT_H, CADP_OP_DIVISION_SETUP_HALF_UNSIGNED
  } cadp_op_t;

endpackage

/* hdl/cadp_core.sv */
// Conditional arithmetic and divide datapath with a classic Wishbone register slave.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module cadp_core
  import cadp_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic data_access_outstanding,
  output logic data_access_hold,
  output logic debug_event,
  output logic global_interrupt_enable_bit
);

  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] lead_zeroes(input logic [15:0] v, input int width);
    logic [4:0] n;
    logic seen;
    n = 5'h00;
    seen = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (i < width && !seen) begin
        if (v[i]) begin
          seen = 1'b1;
        end else begin
          n = n + 5'h01;
        end
      end
    end
    return n;
  endfunction

  function automatic logic [31:0] mag(input logic [31:0] v);
    return v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  // ==========================================================================
  // Bus decode.
  logic ack_q;
  logic [31:0] opa_q, opb_q, opc_q, opd_q, ctrl_q, res_lo_q, res_hi_q, rdata_q;
  logic v_q, sv_q, av_q, sav_q, dbg_st_q, busy_q, ie_q, dbg_en_q, dbg_evt_q;

  wire req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wr = req && wb_we_i;
  wire [7:0] adr = 8'(wb_adr_i);
  wire wr_opa = wr && adr == CADP_OFF_OPA;
  wire wr_opb = wr && adr == CADP_OFF_OPB;
  wire wr_opc = wr && adr == CADP_OFF_OPC;
  wire wr_opd = wr && adr == CADP_OFF_OPD;
  wire wr_ctrl = wr && adr == CADP_OFF_CTRL && wb_sel_i[0];
  wire wr_status = wr && adr == CADP_OFF_STATUS && wb_sel_i[0];
  wire wr_icr = wr && adr == CADP_OFF_ICR && wb_sel_i[0];
  wire wr_cfg = wr && adr == CADP_OFF_CFG && wb_sel_i[0];

  // A control write launches the operation with the control word it carries.
  wire exec = wr_ctrl;
  wire [31:0] cw = merge_bytes(ctrl_q, wb_dat_i, wb_sel_i);
  wire cadp_op_t op = cadp_op_t'(cw[CADP_CTRL_OP_LSB +: 5]);
  wire use_imm = cw[CADP_CTRL_IMM_BIT];
  wire [31:0] k4 = {{28{cw[CADP_CTRL_K4_LSB+3]}}, cw[CADP_CTRL_K4_LSB +: 4]};
  wire [4:0] pos_imm = cw[CADP_CTRL_POS_LSB +: 5];
  wire [1:0] scale = cw[CADP_CTRL_SC_LSB +: 2];

  // ==========================================================================
  // Packed leading-zero counts.
  wire [31:0] clz_b, clz_h;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      assign clz_b[8*g +: 8] = {3'b000, lead_zeroes({8'h00, opa_q[8*g +: 8]}, 8)};
    end
    for (g = 0; g < 2; g++) begin : g_half
      assign clz_h[16*g +: 16] = {11'h000, lead_zeroes(opa_q[16*g +: 16], 16)};
    end
  endgenerate

  // ==========================================================================
  // Conditional move and subtract.
  wire cond_nz = opc_q != 32'h0000_0000;
  wire [31:0] mv_src = use_imm ? k4 : opb_q;
  wire [31:0] cmov_r = cond_nz ? mv_src : opd_q;
  wire [31:0] cmovn_r = cond_nz ? opd_q : mv_src;
  wire [31:0] diff = opa_q - opb_q;
  wire sub_ovf = (opa_q[31] ^ opb_q[31]) && (diff[31] ^ opa_q[31]);
  wire do_sub = (op == CADP_OP_CSUB || op == CADP_OP_CSUB_A) ? cond_nz : !cond_nz;
  wire [31:0] csub_r = do_sub ? diff : opa_q;
  wire csub_v = do_sub && sub_ovf;
  wire csub_av = csub_r[31] ^ csub_r[30];

  // ==========================================================================
  // Extract and scaled difference.
  wire [4:0] pos = use_imm ? pos_imm : opc_q[4:0];
  wire [63:0] dext = {opa_q, opb_q} << pos;
  wire [31:0] dextr_r = dext[63:32];
  wire [31:0] difsc_r = 32'($signed(diff) >>> scale);

  // ==========================================================================
  // Division setup. The shift stands in for the early steps, so each later
  // step still meets eight fresh dividend bits at the top of the low word.
  wire dv_signed = op == CADP_OP_DVINIT || op == CADP_OP_DVINIT_B || op == CADP_OP_DVINIT_H;
  wire dv_byte = op == CADP_OP_DVINIT_B || op == CADP_OP_DIVISION_SETUP_BYTE_UNSIGNED;
  wire dv_half = op == CADP_OP_DVINIT_H || op == CADP_OP_DIVISION_SETUP_HALF_UNSIGNED;
  wire [5:0] dv_sh = dv_byte ? CADP_SHIFT_BYTE : (dv_half ? CADP_SHIFT_HALF : CADP_SHIFT_WORD);
  wire [63:0] dv_ext = dv_signed ? {{32{opa_q[31]}}, opa_q} : {32'h0000_0000, opa_q};
  wire dv_qsign = dv_signed && (opa_q[31] ^ opb_q[31]);
  wire [63:0] dv_fill = dv_byte ? CADP_FILL_BYTE : (dv_half ? CADP_FILL_HALF : 64'h0000_0000_0000_0000);
  wire [63:0] dv_init = (dv_ext << dv_sh) | (dv_qsign ? dv_fill : 64'h0000_0000_0000_0000);
  wire [31:0] dv_rem_mag = dv_signed ? mag(dv_init[63:32]) : dv_init[63:32];
  wire [31:0] dv_div_mag = dv_signed ? mag(opb_q) : opb_q;
  wire dv_init_v = dv_rem_mag >= dv_div_mag;

  // ==========================================================================
  // Division adjust: quotient in the low operand, remainder in the high one.
  wire q_neg = opa_q[31];
  wire r_neg = opd_q[31];
  wire adj_exact = r_neg && (~opd_q == mag(opb_q));
  wire [31:0] adj_q = opa_q + {31'h0000_0000, q_neg ^ adj_exact};
  wire [31:0] adj_r = adj_exact ? 32'h0000_0000 : opd_q + {31'h0000_0000, r_neg};
  wire adj_v = !q_neg && adj_q[31];

  // ==========================================================================
  // Result selection.
  logic [31:0] res_lo_d, res_hi_d;
  logic flag_v, flag_av, upd_v, upd_av;
  always_comb begin
    res_lo_d = res_lo_q;
    res_hi_d = res_hi_q;
    flag_v = 1'b0;
    flag_av = 1'b0;
    upd_v = 1'b0;
    upd_av = 1'b0;
    case (op)
      CADP_OP_CLZ_B: res_lo_d = clz_b;
      CADP_OP_CLZ_H: res_lo_d = clz_h;
      CADP_OP_CMOV: res_lo_d = cmov_r;
      CADP_OP_CMOVN: res_lo_d = cmovn_r;
      CADP_OP_CSUB, CADP_OP_CSUBN: begin
        res_lo_d = csub_r;
        flag_v = csub_v;
        flag_av = csub_av;
        upd_v = 1'b1;
        upd_av = 1'b1;
      end
      CADP_OP_CSUB_A, CADP_OP_CSUBN_A: res_lo_d = csub_r;
      CADP_OP_DEXTR: res_lo_d = dextr_r;
      CADP_OP_DIFSC: res_lo_d = difsc_r;
      CADP_OP_DVADJ: begin
        res_lo_d = adj_q;
        res_hi_d = adj_r;
        flag_v = adj_v;
        upd_v = 1'b1;
      end
      CADP_OP_DVINIT, CADP_OP_DVINIT_U, CADP_OP_DVINIT_B, CADP_OP_DIVISION_SETUP_BYTE_UNSIGNED,
      CADP_OP_DVINIT_H, CADP_OP_DIVISION_SETUP_HALF_UNSIGNED: begin
        res_lo_d = dv_init[31:0];
        res_hi_d = dv_init[63:32];
        flag_v = dv_init_v;
        upd_v = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // ==========================================================================
  // Events, status and core control bits.
  wire is_dbg = exec && op == CADP_OP_DEBUG;
  wire dbg_fire = is_dbg && dbg_en_q;
  wire is_dsync = exec && op == CADP_OP_DSYNC;
  wire set_v = exec && upd_v && flag_v;
  wire set_av = exec && upd_av && flag_av;
  wire [31:0] clr = wr_status ? wb_dat_i : 32'h0000_0000;

  // Sticky bits: a set in the same cycle as a clear wins.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      v_q <= 1'b0;
      av_q <= 1'b0;
      sv_q <= 1'b0;
      sav_q <= 1'b0;
      dbg_st_q <= 1'b0;
    end else begin
      v_q <= (exec && upd_v) ? flag_v : v_q;
      av_q <= (exec && upd_av) ? flag_av : av_q;
      sv_q <= (sv_q && !clr[CADP_ST_SV]) || set_v;
      sav_q <= (sav_q && !clr[CADP_ST_SAV]) || set_av;
      dbg_st_q <= (dbg_st_q && !clr[CADP_ST_DBG]) || dbg_fire;
    end
  end

  // The barrier is raised at once so no later access slips past it while the
  // memory side still reports outstanding work.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_q <= 1'b0;
      dbg_evt_q <= 1'b0;
      ie_q <= 1'b0;
      dbg_en_q <= 1'b0;
    end else begin
      busy_q <= is_dsync ? data_access_outstanding : (busy_q && data_access_outstanding);
      dbg_evt_q <= dbg_fire;
      if (exec && op == CADP_OP_DISABLE) begin
        ie_q <= 1'b0;
      end else if (exec && op == CADP_OP_ENABLE) begin
        ie_q <= 1'b1;
      end else if (wr_icr) begin
        ie_q <= wb_dat_i[CADP_GLOBAL_INTERRUPT_ENABLE_BIT];
      end
      if (wr_cfg) begin
        dbg_en_q <= wb_dat_i[CADP_CFG_DBG_EN];
      end
    end
  end

  // ==========================================================================
  // Operand, control and result registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opa_q <= CADP_RST_WORD;
      opb_q <= CADP_RST_WORD;
      opc_q <= CADP_RST_WORD;
      opd_q <= CADP_RST_WORD;
      ctrl_q <= CADP_RST_WORD;
      res_lo_q <= CADP_RST_WORD;
      res_hi_q <= CADP_RST_WORD;
    end else begin
      opa_q <= wr_opa ? merge_bytes(opa_q, wb_dat_i, wb_sel_i) : opa_q;
      opb_q <= wr_opb ? merge_bytes(opb_q, wb_dat_i, wb_sel_i) : opb_q;
      opc_q <= wr_opc ? merge_bytes(opc_q, wb_dat_i, wb_sel_i) : opc_q;
      opd_q <= wr_opd ? merge_bytes(opd_q, wb_dat_i, wb_sel_i) : opd_q;
      ctrl_q <= exec ? cw : ctrl_q;
      res_lo_q <= exec ? res_lo_d : res_lo_q;
      res_hi_q <= exec ? res_hi_d : res_hi_q;
    end
  end

  // ==========================================================================
  // Read path; unmapped addresses answer with zero.
  wire [31:0] status_w = {26'h000_0000, busy_q, dbg_st_q, sav_q, av_q, sv_q, v_q};
  logic [31:0] rd_mux;
  always_comb begin
    case (adr)
      CADP_OFF_OPA: rd_mux = opa_q;
      CADP_OFF_OPB: rd_mux = opb_q;
      CADP_OFF_OPC: rd_mux = opc_q;
      CADP_OFF_OPD: rd_mux = opd_q;
      CADP_OFF_CTRL: rd_mux = ctrl_q;
      CADP_OFF_RES_LO: rd_mux = res_lo_q;
      CADP_OFF_RES_HI: rd_mux = res_hi_q;
      CADP_OFF_STATUS: rd_mux = status_w;
      CADP_OFF_ICR: rd_mux = {31'h0000_0000, ie_q};
      CADP_OFF_CFG: rd_mux = {31'h0000_0000, dbg_en_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= CADP_RST_WORD;
    end else begin
      ack_q <= req;
      rdata_q <= req ? rd_mux : rdata_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign data_access_hold = busy_q;
  assign debug_event = dbg_evt_q;
  assign global_interrupt_enable_bit = ie_q;

  // ==========================================================================
  // Assertions.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack stood for more than one cycle.");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Request not answered in one cycle.");
  a_debug_gated: assert property (is_dbg && !dbg_en_q |=> !debug_event)
    else $error("Debug event raised while debug disabled.");
  a_debug_fire: assert property (is_dbg && dbg_en_q |=> debug_event ##1 !debug_event)
    else $error("Debug event not a single pulse.");
  a_ie_clear: assert property (exec && op == CADP_OP_DISABLE |=> !global_interrupt_enable_bit)
    else $error("Interrupt enable not cleared.");
  a_ie_set: assert property (exec && op == CADP_OP_ENABLE |=> global_interrupt_enable_bit)
    else $error("Interrupt enable not set.");
  a_barrier_hold: assert property (is_dsync && data_access_outstanding |=> data_access_hold)
    else $error("Barrier did not hold later accesses.");
  a_cmov_keep: assert property (exec && op == CADP_OP_CMOV && !cond_nz |=> res_lo_q == $past(opd_q))
    else $error("Conditional move changed destination.");
  a_csub_pass: assert property (exec && op == CADP_OP_CSUBN && cond_nz |=> res_lo_q == $past(opa_q))
    else $error("Inverted subtract did not pass operand.");
  a_clz_zero: assert property (exec && op == CADP_OP_CLZ_B && opa_q == 32'h0000_0000 |=>
    res_lo_q == 32'h0808_0808)
    else $error("Zero bytes did not count eight.");
  a_dvinit_fill: assert property (exec && op == CADP_OP_DIVISION_SETUP_BYTE_UNSIGNED |=> res_lo_q[23:0] == 24'h00_0000)
    else $error("Unsigned setup fill not zero.");
  a_sv_sticky: assert property (set_v |=> sv_q && v_q)
    else $error("Overflow not recorded as sticky.");
  a_sav_sticky: assert property (set_av |=> sav_q && av_q)
    else $error("Advance overflow not recorded as sticky.");

  // A failed condition must leave the old value in place, not a stale result; word setup, zero halfword count and barrier checks follow.
  a_cmovn_keep: assert property (exec && op == CADP_OP_CMOVN && cond_nz |=> res_lo_q == $past(opd_q))
    else $error("Inverted move changed destination.");
  a_csub_keep: assert property (exec && op == CADP_OP_CSUB && !cond_nz |=> res_lo_q == $past(opa_q))
    else $error("Subtract did not pass operand.");
  a_csuba_keep: assert property (exec && op == CADP_OP_CSUB_A && !cond_nz |=>
    res_lo_q == $past(opa_q))
    else $error("Address subtract did not pass operand.");
  a_csubna_keep: assert property (exec && op == CADP_OP_CSUBN_A && cond_nz |=>
    res_lo_q == $past(opa_q))
    else $error("Inverted address subtract did not pass operand.");
  a_dvinit_word: assert property (exec && op == CADP_OP_DVINIT_U |=>
    res_lo_q == $past(opa_q) && res_hi_q == 32'h0000_0000)
    else $error("Unsigned word setup not a plain zero extension.");
  a_clz_half: assert property (exec && op == CADP_OP_CLZ_H && opa_q == 32'h0000_0000 |=>
    res_lo_q == 32'h0010_0010)
    else $error("Zero halfwords did not count sixteen.");
  a_barrier_idle: assert property (is_dsync && !data_access_outstanding |=> !data_access_hold)
    else $error("Barrier held with nothing outstanding.");
  a_barrier_free: assert property (data_access_hold && !data_access_outstanding && !is_dsync |=>
    !data_access_hold)
    else $error("Barrier not released after accesses drained.");

endmodule
`default_nettype wire

/* dv/cadp_mem_model.sv */
// Memory-system stand-in that keeps data accesses in flight for the barrier tests.
`timescale 1ns/100ps
`default_nettype none
module cadp_mem_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req,
  input wire logic [7:0] len,
  input wire logic data_access_hold,
  output logic data_access_outstanding
);
  // ==========================================================================
  // In-flight counter.
  logic [7:0] cnt_q;
  // A new access is ignored while the barrier holds, so a late start cannot slip past it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (req && !data_access_hold) begin
      cnt_q <= len;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign data_access_outstanding = (cnt_q != 8'h00);
endmodule
`default_nettype wire

/* dv/cond_arith_divide_datapath_tb.sv */
// Self-checking bench for the conditional arithmetic datapath with a reference model.
`timescale 1ns/100ps
`default_nettype none
module cond_arith_divide_datapath_tb;
  import cadp_pkg::*;
  // ==========================================================================
  // Signals and instances.
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic data_access_outstanding;
  logic data_access_hold;
  logic debug_event;
  logic global_interrupt_enable_bit;
  logic mem_req = 1'b0;
  logic [7:0] mem_len = 8'h00;
  logic [31:0] lo, hi, st, x;
  int err_total = 0;
  int checks = 0;
  int dbg_cnt = 0;
  logic sv_m = 1'b0;
  logic sav_m = 1'b0;
  cadp_op_t ops[10] = '{CADP_OP_CLZ_B, CADP_OP_CLZ_H, CADP_OP_CMOV, CADP_OP_CMOVN, CADP_OP_CSUB,
    CADP_OP_CSUBN, CADP_OP_CSUB_A, CADP_OP_CSUBN_A, CADP_OP_DEXTR, CADP_OP_DIFSC};
  logic [7:0] offs[4] = '{CADP_OFF_ICR, CADP_OFF_CFG, CADP_OFF_STATUS, 8'h30};
  cadp_core #(.ADDR_W(8)) i_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .data_access_outstanding(data_access_outstanding), .data_access_hold(data_access_hold),
    .debug_event(debug_event), .global_interrupt_enable_bit(global_interrupt_enable_bit));
  cadp_mem_model i_mem (.clk_sys(clk_sys), .rst(rst), .req(mem_req), .len(mem_len),
    .data_access_hold(data_access_hold), .data_access_outstanding(data_access_outstanding));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (debug_event === 1'b1) begin
      dbg_cnt++;
    end
  end
  // ==========================================================================
  // Tasks and reference functions.
  task automatic tally_and_finish();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // The idle edge at entry keeps cyc and stb low for a cycle between accesses.
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
    output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t bus timeout", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, 4'hF, x);
  endtask
  task automatic rd(input logic [7:0] adr, output logic [31:0] dat);
    wb_xfer(1'b0, adr, 32'h0, 4'hF, dat);
  endtask
  task automatic exec(input logic [31:0] a, b, c, d, ctrl);
    wr(CADP_OFF_OPA, a);
    wr(CADP_OFF_OPB, b);
    wr(CADP_OFF_OPC, c);
    wr(CADP_OFF_OPD, d);
    wr(CADP_OFF_CTRL, ctrl);
    rd(CADP_OFF_RES_LO, lo);
    rd(CADP_OFF_RES_HI, hi);
    rd(CADP_OFF_STATUS, st);
  endtask
  function automatic logic [31:0] clzp(input logic [31:0] v, input int w);
    logic [31:0] r;
    int n;
    r = 32'h0;
    for (int f = 0; f < 32; f += w) begin
      n = 0;
      while (n < w && v[f + w - 1 - n] == 1'b0) begin
        n++;
      end
      r = r | (32'(n) << f);
    end
    return r;
  endfunction
  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] a, b, c, d, e;
    logic [63:0] t;
    logic [3:0] k4;
    logic [4:0] pos;
    logic [1:0] sc;
    logic imm, tk, v;
    int k, n0, lag, sh;
    longint mh, mb;
    void'($urandom(36));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (offs[i]) begin
      rd(offs[i], x);
      chk(x, 32'h0, "reset value");
    end
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, x);
    chk(x, 32'h0, "unmapped");
    for (int i = 0; i < 60; i++) begin
      k = i % 10;
      a = $urandom >> ($urandom % 32);
      if (i % 20 < 2) begin
        a = (i < 20) ? 32'h0 : (a & 32'h00FF_0000);
      end
      b = $urandom;
      c = ((i / 10) % 2 == 1) ? $urandom : 32'h0;
      d = $urandom;
      k4 = 4'($urandom);
      pos = 5'($urandom);
      sc = 2'($urandom);
      imm = ((i / 20) % 2 == 1);
      tk = ((c != 32'h0) == (k % 2 == 0));
      case (k)
        0: e = clzp(a, 8);
        1: e = clzp(a, 16);
        2, 3: e = tk ? (imm ? {{28{k4[3]}}, k4} : b) : d;
        8: begin
          t = {a, b} << (imm ? pos : c[4:0]);
          e = t[63:32];
        end
        9: e = 32'($signed(a - b) >>> sc);
        default: e = tk ? a - b : a;
      endcase
      v = tk && (a[31] != b[31]) && (e[31] != a[31]);
      exec(a, b, c, d, {15'h0, sc, pos, k4, imm, ops[k]});
      chk(lo, e, "datapath");
      if (k == 4 || k == 5) begin
        sv_m = sv_m | v;
        sav_m = sav_m | (e[31] ^ e[30]);
        chk(st & 32'hF, {28'h0, sav_m, e[31] ^ e[30], sv_m, v}, "sub flags");
      end
    end
    // No adjust follows any setup form, signed or unsigned; the adjust checks below use their own operands.
    for (int i = 0; i < 24; i++) begin
      k = i % 6;
      sh = (k < 2) ? 0 : ((k < 4) ? 24 : 16);
      a = $urandom;
      b = (i < 12) ? $urandom : ($urandom >> 20);
      t = (k % 2 == 0) ? {{32{a[31]}}, a} : {32'h0, a};
      t = t << sh;
      if (k % 2 == 0 && (a[31] ^ b[31])) begin
        t = t | ((64'h1 << sh) - 64'h1);
      end
      mh = (k % 2 == 0) ? longint'($signed(t[63:32])) : longint'(t[63:32]);
      mb = (k % 2 == 0) ? longint'($signed(b)) : longint'(b);
      mh = (mh < 0) ? -mh : mh;
      mb = (mb < 0) ? -mb : mb;
      exec(a, b, 32'h0, 32'h0, {27'h0, 5'(int'(CADP_OP_DVINIT) + k)});
      chk(lo, t[31:0], "setup low");
      chk(hi, t[63:32], "setup high");
      sv_m = sv_m | (mh >= mb);
      chk(st & 32'hB, {28'h0, sav_m, 1'b0, sv_m, mh >= mb}, "setup overflow");
    end
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 32'h7FFF_FFFF : ((i == 1) ? 32'hFFFF_FFFC : $urandom);
      b = (i < 2) ? 32'h4 : $urandom;
      d = (i < 2) ? 32'hFFFF_FFFB : $urandom;
      mb = longint'($signed(b));
      mb = (mb < 0) ? -mb : mb;
      tk = d[31] && (~d == mb[31:0]);
      e = a + {31'h0, a[31] ^ tk};
      exec(a, b, 32'h0, d, {27'h0, CADP_OP_DVADJ});
      chk(lo, e, "adjust quotient");
      chk(hi, tk ? 32'h0 : d + {31'h0, d[31]}, "adjust remainder");
      sv_m = sv_m | (!a[31] && e[31]);
      chk(st & 32'hB, {28'h0, sav_m, 1'b0, sv_m, !a[31] && e[31]}, "adjust overflow");
    end
    exec(32'h0, 32'h0, 32'h0, 32'h0, {27'h0, CADP_OP_NOP});
    chk(lo, e, "nop keeps result");
    chk(st & 32'hB, {28'h0, sav_m, 1'b0, sv_m, !a[31] && e[31]}, "nop keeps flags");
    wr(CADP_OFF_CTRL, {27'h0, CADP_OP_ENABLE});
    rd(CADP_OFF_ICR, x);
    chk({30'h0, x[0], global_interrupt_enable_bit}, 32'h3, "enable");
    wr(CADP_OFF_CTRL, {27'h0, CADP_OP_DISABLE});
    rd(CADP_OFF_ICR, x);
    chk({30'h0, x[0], global_interrupt_enable_bit}, 32'h0, "disable");
    wb_xfer(1'b1, CADP_OFF_ICR, 32'h1, 4'hE, x);
    rd(CADP_OFF_ICR, x);
    chk(x, 32'h0, "lane zero off");
    for (int en = 0; en < 2; en++) begin
      wr(CADP_OFF_CFG, 32'(en));
      n0 = dbg_cnt;
      wr(CADP_OFF_CTRL, {27'h0, CADP_OP_DEBUG});
      repeat (2) @(posedge clk_sys);
      chk(32'(dbg_cnt - n0), 32'(en), "debug event");
    end
    rd(CADP_OFF_STATUS, st);
    chk(st & 32'h1A, {27'h0, 1'b1, sav_m, 1'b0, sv_m, 1'b0}, "sticky before clear");
    wr(CADP_OFF_STATUS, 32'h0000_001A);
    rd(CADP_OFF_STATUS, st);
    chk(st & 32'h1A, 32'h0, "sticky cleared");
    @(posedge clk_sys);
    mem_len <= 8'h1E;
    mem_req <= 1'b1;
    @(posedge clk_sys);
    mem_req <= 1'b0;
    wr(CADP_OFF_CTRL, {27'h0, CADP_OP_DSYNC});
    @(negedge clk_sys);
    chk({31'h0, data_access_hold}, 32'h1, "barrier held");
    lag = 0;
    for (n0 = 0; n0 < 100 && data_access_hold === 1'b1; n0++) begin
      lag += (data_access_outstanding === 1'b0) ? 1 : 0;
      @(negedge clk_sys);
    end
    if (data_access_hold === 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t barrier timeout", $time);
      tally_and_finish();
    end
    chk(32'(lag), 32'h1, "barrier release");
    wr(CADP_OFF_CTRL, {27'h0, CADP_OP_DSYNC});
    @(negedge clk_sys);
    chk({31'h0, data_access_hold}, 32'h0, "barrier idle");
    tally_and_finish();
  end
endmodule
`default_nettype wire
